// [rtl/diag_cfg_pkg.sv]
// Register map, field layout, timing and types of the input fault diagnostics
package diag_cfg_pkg;

    localparam logic [7:0] ADDR_SCAN_ENABLE = 8'h64;
    localparam logic [7:0] ADDR_TERM_THR    = 8'h65;
    localparam logic [7:0] ADDR_SHORT_THR   = 8'h66;
    localparam logic [7:0] ADDR_SCAN_TIMING = 8'h67;
    localparam logic [7:0] ADDR_AVERAGING   = 8'h68;
    localparam logic [7:0] ADDR_BOOST       = 8'h6a;

    localparam logic [7:0] RST_SCAN_ENABLE  = 8'h00;
    localparam logic [7:0] RST_TERM_THR     = 8'h37;
    localparam logic [7:0] RST_SHORT_THR    = 8'h87;
    localparam logic [7:0] RST_SCAN_TIMING  = 8'hb8;
    localparam logic [7:0] RST_AVERAGING    = 8'h00;
    localparam logic [7:0] RST_BOOST        = 8'h00;

    // Read-only bits never take a written value
    localparam logic [7:0] WMASK_AVERAGING  = 8'hf0;
    localparam logic [7:0] WMASK_BOOST      = 8'hf8;

    localparam int CH_EN_MSB       = 7;
    localparam int GND_THR_LSB     = 4;
    localparam int BIAS_THR_LSB    = 0;
    localparam int TERM_THR_LSB    = 4;
    localparam int BATT_THR_LSB    = 0;
    localparam int REPEAT_LSB      = 6;
    localparam int FILT_SEL_LSB    = 2;
    localparam int BATT_FILT_BIT   = 1;
    localparam int DOUBLE_BIT      = 0;
    localparam int AVG_LSB         = 6;
    localparam int LOAD_BYP_BIT    = 5;
    localparam int TEMP_BYP_BIT    = 4;
    localparam int STEP_UP_OFF_BIT = 7;

    localparam logic [11:0] GND_STEP_MV  = 12'd60;
    localparam logic [11:0] FINE_STEP_MV = 12'd30;

    // Load and temperature trip levels come from trim; plain defaults here
    localparam logic [11:0] LOAD_LIMIT   = 12'h800;
    localparam logic [11:0] TEMP_LIMIT   = 12'h800;

    localparam int CLK_MHZ           = 125;
    localparam int REPEAT_1_US       = 1000;
    localparam int REPEAT_4_US       = 4000;
    localparam int REPEAT_8_US       = 8000;
    localparam int REPEAT_1_CYCLES   = REPEAT_1_US * CLK_MHZ;
    localparam int REPEAT_4_CYCLES   = REPEAT_4_US * CLK_MHZ;
    localparam int REPEAT_8_CYCLES   = REPEAT_8_US * CLK_MHZ;

    localparam logic [4:0] FILT_16   = 5'd16;
    localparam logic [4:0] FILT_8    = 5'd8;
    localparam logic [4:0] FILT_4    = 5'd4;
    localparam logic [4:0] FILT_NONE = 5'd1;

    localparam logic [1:0] AVG_OFF     = 2'h0;
    localparam logic [1:0] AVG_HALF    = 2'h1;
    localparam logic [1:0] AVG_QUARTER = 2'h2;

    localparam int MEM_WORDS = 32;

    typedef enum logic [2:0] {
        K_GND   = 3'b000,
        K_BIAS  = 3'b001,
        K_TERM  = 3'b010,
        K_BATT  = 3'b011,
        K_LOAD  = 3'b100,
        K_TEMP  = 3'b101
    } fault_kind_e;

    typedef enum logic {
        ST_CLEAR = 1'b0,
        ST_RUN   = 1'b1
    } run_state_e;

    typedef struct packed {
        logic [1:0]  ch;
        logic [2:0]  kind;
        logic [11:0] value;
    } sample_s;

    typedef struct packed {
        logic        vld;
        logic [4:0]  cnt;
        logic [11:0] avg;
    } mem_word_s;

    function automatic logic [11:0] thr_mv(input logic [3:0] code,
                                           input logic [11:0] step,
                                           input logic dbl);
        logic [11:0] t;
        t = 12'(code) * step;
        if (dbl) t = {t[10:0], 1'b0};
        return t;
    endfunction

    function automatic logic [4:0] need_count(input logic [1:0] sel);
        logic [4:0] n;
        unique case (sel)
            2'h0: n = FILT_16;
            2'h1: n = FILT_8;
            2'h2: n = FILT_4;
            2'h3: n = FILT_NONE;
        endcase
        return n;
    endfunction

endpackage

// [rtl/diag_word_mem.sv]
// Per channel and fault kind store of averaged value and debounce count
`timescale 1ns/10ps
`default_nettype none
module diag_word_mem
    import diag_cfg_pkg::*;
(
    input  wire logic       clk_in,
    // Write side
    input  wire logic       we_in,
    input  wire logic [4:0] waddr_in,
    input  wire mem_word_s  wdata_in,
    // Read side, data one cycle later
    input  wire logic [4:0] raddr_in,
    output mem_word_s       rdata_out
);
    mem_word_s mem [MEM_WORDS];

    always_ff @(posedge clk_in) begin
        if (we_in) mem[waddr_in] <= wdata_in;
        rdata_out <= mem[raddr_in];
    end
endmodule
`default_nettype wire

// [rtl/input_fault_diag_config.sv]
// Input fault diagnostics configuration registers, scan pacing and filtering
`timescale 1ns/10ps
`default_nettype none
module input_fault_diag_config
    import diag_cfg_pkg::*;
#(
    parameter int REP1_CYCLES = REPEAT_1_CYCLES,
    parameter int REP4_CYCLES = REPEAT_4_CYCLES,
    parameter int REP8_CYCLES = REPEAT_8_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    // Register port from the control interface
    input  wire logic [7:0]  REG_ADDR_IN,
    input  wire logic        REG_WR_IN,
    input  wire logic [7:0]  REG_WDATA_IN,
    input  wire logic        REG_RD_IN,
    output logic [7:0]       REG_RDATA_OUT,
    // Scan sequencer
    input  wire logic        SCAN_BUSY_IN,
    output logic             SCAN_START_OUT,
    input  wire logic        SAMPLE_VALID_IN,
    input  wire sample_s     SAMPLE_IN,
    input  wire logic        VBAT_BELOW_BIAS_IN,
    // Status and controls
    output logic [3:0]       CHAN_SCAN_EN_OUT,
    output logic             STEP_UP_OFF_OUT,
    output logic [23:0]      FAULT_OUT
);
    logic [7:0]  scan_en_q, term_thr_q, short_thr_q;
    logic [7:0]  timing_q, avg_cfg_q, boost_q;
    logic [7:0]  rdata_q;
    logic [19:0] tmr_q;
    logic        start_q;
    run_state_e  state_q;
    logic [4:0]  clr_idx_q;
    logic        s1_vld_q;
    sample_s     s1_q;
    logic        s1_vlow_q;
    logic        fwd_vld_q;
    logic [4:0]  fwd_addr_q;
    mem_word_s   fwd_word_q;
    logic [23:0] fault_q;
    logic [3:0]  chan_en_q;
    logic        step_up_off_q;

    // Register decode
    wire wr_scan_en  = REG_WR_IN && REG_ADDR_IN == ADDR_SCAN_ENABLE;
    wire wr_term     = REG_WR_IN && REG_ADDR_IN == ADDR_TERM_THR;
    wire wr_short    = REG_WR_IN && REG_ADDR_IN == ADDR_SHORT_THR;
    wire wr_timing   = REG_WR_IN && REG_ADDR_IN == ADDR_SCAN_TIMING;
    wire wr_avg      = REG_WR_IN && REG_ADDR_IN == ADDR_AVERAGING;
    wire wr_boost    = REG_WR_IN && REG_ADDR_IN == ADDR_BOOST;
    wire [7:0] rd_mux =
        (REG_ADDR_IN == ADDR_SCAN_ENABLE) ? scan_en_q   :
        (REG_ADDR_IN == ADDR_TERM_THR)    ? term_thr_q  :
        (REG_ADDR_IN == ADDR_SHORT_THR)   ? short_thr_q :
        (REG_ADDR_IN == ADDR_SCAN_TIMING) ? timing_q    :
        (REG_ADDR_IN == ADDR_AVERAGING)   ? avg_cfg_q   :
        (REG_ADDR_IN == ADDR_BOOST)       ? boost_q     : 8'h00;

    // Field extraction
    wire [3:0] ch_en    = {scan_en_q[CH_EN_MSB-3], scan_en_q[CH_EN_MSB-2],
                           scan_en_q[CH_EN_MSB-1], scan_en_q[CH_EN_MSB]};
    wire [1:0] repeat_c = timing_q[REPEAT_LSB+:2];
    wire [1:0] filt_sel = timing_q[FILT_SEL_LSB+:2];
    wire       batt_f8  = timing_q[BATT_FILT_BIT];
    wire       dbl      = timing_q[DOUBLE_BIT];
    wire [1:0] avg_mode = avg_cfg_q[AVG_LSB+:2];
    wire       load_byp = avg_cfg_q[LOAD_BYP_BIT];
    wire       temp_byp = avg_cfg_q[TEMP_BYP_BIT];

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            scan_en_q   <= RST_SCAN_ENABLE;
            term_thr_q  <= RST_TERM_THR;
            short_thr_q <= RST_SHORT_THR;
            timing_q    <= RST_SCAN_TIMING;
            avg_cfg_q   <= RST_AVERAGING;
            boost_q     <= RST_BOOST;
            rdata_q     <= 8'h00;
        end else begin
            if (wr_scan_en) scan_en_q <= REG_WDATA_IN;
            if (wr_term) term_thr_q <= REG_WDATA_IN;
            if (wr_short) short_thr_q <= REG_WDATA_IN;
            if (wr_timing) timing_q <= REG_WDATA_IN;
            if (wr_avg) avg_cfg_q <= REG_WDATA_IN & WMASK_AVERAGING;
            if (wr_boost) boost_q <= REG_WDATA_IN & WMASK_BOOST;
            if (REG_RD_IN) rdata_q <= rd_mux;
        end
    end

    // Scan pacing
    wire [19:0] period = (repeat_c == 2'h1) ? 20'(REP1_CYCLES - 1) :
                         (repeat_c == 2'h2) ? 20'(REP4_CYCLES - 1) :
                                              20'(REP8_CYCLES - 1);
    wire any_en   = |ch_en;
    wire tick     = tmr_q == 20'h0;
    wire start_d  = (state_q == ST_RUN) && any_en &&
                    ((repeat_c == 2'h0) ? (!SCAN_BUSY_IN && !start_q) : tick);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tmr_q   <= 20'h0;
            start_q <= 1'b0;
        end else begin
            start_q <= start_d;
            if (!any_en || repeat_c == 2'h0 || tick) tmr_q <= period;
            else tmr_q <= tmr_q - 20'h1;
        end
    end

    // Entry store is swept clear after reset; samples are dropped until it is done
    wire        s0_take  = (state_q == ST_RUN) && SAMPLE_VALID_IN &&
                           SAMPLE_IN.kind <= K_TEMP &&
                           ch_en[SAMPLE_IN.ch];
    wire [4:0]  s0_addr  = {SAMPLE_IN.kind, SAMPLE_IN.ch};
    wire [4:0]  s1_addr  = {s1_q.kind, s1_q.ch};
    mem_word_s  mem_rd;
    mem_word_s  new_word;
    wire        clearing = state_q == ST_CLEAR;

    // Back-to-back samples of one entry would read a stale word
    wire        fwd_hit  = fwd_vld_q && fwd_addr_q == s1_addr;
    mem_word_s  old_word;
    assign old_word = fwd_hit ? fwd_word_q : mem_rd;

    wire byp_kind = (s1_q.kind == K_LOAD && load_byp) ||
                    (s1_q.kind == K_TEMP && temp_byp);
    wire avg_on   = (avg_mode == AVG_HALF || avg_mode == AVG_QUARTER) &&
                    !byp_kind && old_word.vld;
    wire [13:0] sum_half = 14'(old_word.avg) + 14'(s1_q.value);
    wire [13:0] sum_qtr  = 14'(old_word.avg) * 14'd3 + 14'(s1_q.value);
    // Truncating fixed point; a steady input converges to within one LSB in half mode, three LSB in quarter mode
    wire [11:0] avg_val  = !avg_on ? s1_q.value :
                           (avg_mode == AVG_HALF) ? sum_half[12:1] :
                                                    sum_qtr[13:2];

    wire [11:0] thr_gnd  = thr_mv(short_thr_q[GND_THR_LSB+:4],
                                  GND_STEP_MV, dbl);
    wire [11:0] thr_bias = thr_mv(short_thr_q[BIAS_THR_LSB+:4],
                                  FINE_STEP_MV, dbl);
    wire [11:0] thr_term = thr_mv(term_thr_q[TERM_THR_LSB+:4],
                                  FINE_STEP_MV, dbl);
    wire [11:0] thr_batt = thr_mv(term_thr_q[BATT_THR_LSB+:4],
                                  FINE_STEP_MV, dbl);
    wire [11:0] thr_sel  = (s1_q.kind == K_GND)  ? thr_gnd  :
                           (s1_q.kind == K_BIAS) ? thr_bias :
                           (s1_q.kind == K_TERM) ? thr_term :
                           (s1_q.kind == K_BATT) ? thr_batt :
                           (s1_q.kind == K_LOAD) ? LOAD_LIMIT : TEMP_LIMIT;
    wire        is_fault = (s1_q.kind <= K_BATT) ? (avg_val <= thr_sel) :
                                                   (avg_val > thr_sel);

    // Battery level travels with its sample, so the count fits that scan
    wire        batt_case = s1_q.kind == K_BATT && s1_vlow_q;
    wire [4:0]  need     = batt_case ? (batt_f8 ? FILT_8 : FILT_16)
                                     : need_count(filt_sel);
    wire [4:0]  cnt_inc  = (old_word.cnt == FILT_16) ? FILT_16 :
                                                       old_word.cnt + 5'd1;
    wire [4:0]  cnt_new  = is_fault ? cnt_inc : 5'd0;
    wire        flag_set = is_fault && cnt_new >= need;
    assign new_word = '{vld: 1'b1, cnt: cnt_new, avg: avg_val};

    wire        mem_we    = clearing || s1_vld_q;
    wire [4:0]  mem_waddr = clearing ? clr_idx_q : s1_addr;
    mem_word_s  mem_wdata;
    assign mem_wdata = clearing ? '0 : new_word;

    diag_word_mem u_mem (
        .clk_in    (CLK_IN),
        .we_in     (mem_we),
        .waddr_in  (mem_waddr),
        .wdata_in  (mem_wdata),
        .raddr_in  (s0_addr),
        .rdata_out (mem_rd)
    );

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            state_q    <= ST_CLEAR;
            clr_idx_q  <= 5'h0;
            s1_vld_q   <= 1'b0;
            s1_q       <= '0;
            s1_vlow_q  <= 1'b0;
            fwd_vld_q  <= 1'b0;
            fwd_addr_q <= 5'h0;
            fwd_word_q <= '0;
        end else begin
            unique case (state_q)
                ST_CLEAR: begin
                    clr_idx_q <= clr_idx_q + 5'h1;
                    if (clr_idx_q == 5'h1f) state_q <= ST_RUN;
                end
                ST_RUN: state_q <= ST_RUN;
            endcase
            s1_vld_q   <= s0_take;
            s1_q       <= SAMPLE_IN;
            s1_vlow_q  <= VBAT_BELOW_BIAS_IN;
            fwd_vld_q  <= mem_we;
            fwd_addr_q <= mem_waddr;
            fwd_word_q <= mem_wdata;
        end
    end

    // Flags show live, debounced fault state per entry
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            fault_q       <= 24'h0;
            chan_en_q     <= 4'h0;
            step_up_off_q <= 1'b0;
        end else begin
            if (s1_vld_q && flag_set) fault_q[s1_addr] <= 1'b1;
            else if (s1_vld_q && !is_fault) fault_q[s1_addr] <= 1'b0;
            chan_en_q     <= ch_en;
            step_up_off_q <= boost_q[STEP_UP_OFF_BIT];
        end
    end

    assign REG_RDATA_OUT    = rdata_q;
    assign SCAN_START_OUT   = start_q;
    assign CHAN_SCAN_EN_OUT = chan_en_q;
    assign STEP_UP_OFF_OUT  = step_up_off_q;
    assign FAULT_OUT        = fault_q;

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    chk_short_thr_wr: assert property (wr_short |=>
        short_thr_q == $past(REG_WDATA_IN)) else $error("thr write lost");
    chk_gnd_step: assert property (!dbl |->
        thr_gnd == 12'(short_thr_q[7:4]) * 12'd60) else $error("gnd step");
    chk_bias_step: assert property (dbl |->
        thr_bias == 12'(short_thr_q[3:0]) * 12'd60) else $error("scale");
    chk_b2b_scan: assert property (
        start_q && repeat_c == 2'h0 && !SCAN_BUSY_IN |=> !start_q)
        else $error("continuous scan pulse too long");
    chk_paced_gap: assert property (
        start_q && repeat_c != 2'h0 && $stable(timing_q) |=>
        (!start_q || repeat_c == 2'h0) [*8])
        else $error("paced start too soon");
    // A switch to continuous scanning may start at once
    chk_no_debounce: assert property (
        s1_vld_q && is_fault && filt_sel == 2'h3 && !batt_case |=>
        fault_q[$past(s1_addr)]) else $error("no debounce flag late");
    chk_batt_count: assert property (
        batt_case && !batt_f8 |-> need == 5'd16) else $error("batt count");
    chk_avg_bypass: assert property (
        s1_vld_q && s1_q.kind == K_TEMP && temp_byp |->
        avg_val == s1_q.value) else $error("temp bypass");
    chk_step_up: assert property (wr_boost |=> ##1
        STEP_UP_OFF_OUT == $past(REG_WDATA_IN[7], 2))
        else $error("step-up off not applied");
    chk_disabled_ch: assert property (SAMPLE_VALID_IN &&
        !ch_en[SAMPLE_IN.ch] |=> !s1_vld_q) else $error("disabled ch");
    chk_clean_clear: assert property (s1_vld_q && !is_fault |=>
        !fault_q[$past(s1_addr)]) else $error("clean scan kept flag");
    chk_early_flag: assert property (s1_vld_q && is_fault &&
        cnt_new < need && !fault_q[s1_addr] |=> !fault_q[$past(s1_addr)])
        else $error("flag before debounce");
endmodule
`default_nettype wire

// [verif/input_fault_diag_config_tb.sv]
// Self-checking bench for the diagnostics configuration block
`timescale 1ns/10ps
`default_nettype none
module input_fault_diag_config_tb;
    import diag_cfg_pkg::*;
    localparam logic [7:0] RV [0:6] = '{8'h00, 8'h37, 8'h87, 8'hb8,
                                        8'h00, 8'h00, 8'h00};
    // Read-only and unmapped bits never take written data
    localparam logic [7:0] WM [0:6] = '{8'hff, 8'hff, 8'hff, 8'hff,
                                        8'hf0, 8'h00, 8'hf8};
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        busy = 1'b0;
    logic        svld = 1'b0;
    logic        vlow = 1'b0;
    logic        live = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [7:0]  wdata = 8'h00;
    sample_s     smp = '0;
    logic [7:0]  rdata;
    logic        start;
    logic        step_off;
    logic [3:0]  chan_en;
    logic [23:0] fault;
    int          mismatches = 0;
    int          checked = 0;
    int          seed = 21;
    logic [7:0]  mregs [0:6];
    logic [4:0]  mcnt [0:23];
    int          mavg [0:23];
    logic        mvld [0:23];
    logic [23:0] mflag, d1, d2;
    logic [4:0]  dctl;

    always #4 clk = ~clk;

    input_fault_diag_config #(
        .REP1_CYCLES(20),
        .REP4_CYCLES(40),
        .REP8_CYCLES(80)
    ) dut (
        .CLK_IN(clk), .RST_N_IN(rst_n),
        .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_WDATA_IN(wdata),
        .REG_RD_IN(rd), .REG_RDATA_OUT(rdata),
        .SCAN_BUSY_IN(busy), .SCAN_START_OUT(start),
        .SAMPLE_VALID_IN(svld), .SAMPLE_IN(smp),
        .VBAT_BELOW_BIAS_IN(vlow), .CHAN_SCAN_EN_OUT(chan_en),
        .STEP_UP_OFF_OUT(step_off), .FAULT_OUT(fault)
    );

    // Reference model; flags lag one edge behind the sample edge
    always @(posedge clk or negedge rst_n) begin : model
        int e, thr, v, nd;
        logic f;
        if (!rst_n) begin
            for (int i = 0; i < 7; i++) mregs[i] <= RV[i];
            for (int i = 0; i < 24; i++) mcnt[i] = 5'd0;
            for (int i = 0; i < 24; i++) mvld[i] = 1'b0;
            mflag = '0;
            d1 <= '0;
            d2 <= '0;
            dctl <= '0;
        end else begin
            if (svld && smp.kind <= 3'd5 && mregs[0][7 - smp.ch]) begin
                e = smp.kind * 4 + smp.ch;
                v = smp.value;
                if (mvld[e] && !(smp.kind == 3'd4 && mregs[4][5])
                    && !(smp.kind == 3'd5 && mregs[4][4])) begin
                    if (mregs[4][7:6] == 2'h1) v = (mavg[e] + v) / 2;
                    if (mregs[4][7:6] == 2'h2) v = (3 * mavg[e] + v) / 4;
                end
                mavg[e] = v;
                mvld[e] = 1'b1;
                case (smp.kind)
                    3'd0: thr = mregs[2][7:4] * 60;
                    3'd1: thr = mregs[2][3:0] * 30;
                    3'd2: thr = mregs[1][7:4] * 30;
                    3'd3: thr = mregs[1][3:0] * 30;
                    default: thr = 0;
                endcase
                if (mregs[3][0]) thr = thr * 2;
                f = (smp.kind > 3'd3) ? (v > 'h800) : (v <= thr);
                nd = (mregs[3][3:2] == 2'h3) ? 1 : 16 >> mregs[3][3:2];
                if (smp.kind == 3'd3 && vlow) nd = mregs[3][1] ? 8 : 16;
                if (!f) mcnt[e] = 5'd0;
                else if (mcnt[e] < 5'd16) mcnt[e] = mcnt[e] + 5'd1;
                if (!f) mflag[e] = 1'b0;
                else if (mcnt[e] >= nd) mflag[e] = 1'b1;
            end
            if (wr && addr >= 8'h64 && addr <= 8'h6a)
                mregs[addr - 8'h64] <= wdata & WM[addr - 8'h64];
            d1 <= mflag;
            d2 <= d1;
            dctl <= {mregs[6][7], mregs[0][4], mregs[0][5],
                     mregs[0][6], mregs[0][7]};
        end
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] reg %h exp %h got %h", addr, e, g);
        end
    endtask

    task automatic chk_out(input string n, input logic [23:0] e,
                           input logic [23:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_gap(input int e, input int g);
        checked++;
        if (g != e) begin
            mismatches++;
            $display("[ERR] start gap exp %0d got %0d", e, g);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick();
        wr = 1'b0;
        tick();
    endtask

    task automatic reg_rd(input logic [7:0] a);
        logic [7:0] e;
        addr = a;
        rd = 1'b1;
        tick();
        rd = 1'b0;
        e = (a >= 8'h64 && a <= 8'h6a) ? mregs[a - 8'h64] : 8'h00;
        tick();
        chk_reg(e, rdata);
    endtask

    // Cycles until the next start pulse; 300 means none came
    task automatic gap(output int g);
        g = 0;
        do begin
            tick();
            g++;
        end while (start !== 1'b1 && g < 300);
    endtask

    task automatic pace(input logic [1:0] code, input int e);
        int g;
        reg_wr(8'h67, {code, 6'h38});
        gap(g);
        gap(g);
        gap(g);
        chk_gap(e, g);
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(negedge clk) begin
        if (rst_n && live) begin
            chk_out("flags", d2, fault);
            chk_out("ctl", 24'(dctl), 24'({step_off, chan_en}));
        end
    end

    initial begin
        #400000;
        mismatches++;
        stop_test();
    end

    initial begin
        int r, v, g, n;
        logic f;
        tick(20);
        chk_out("reset", 24'h0, fault | 24'({start, step_off, chan_en}));
        rst_n = 1'b1;
        live = 1'b1;
        for (int a = 8'h64; a <= 8'h6b; a++) reg_rd(8'(a));
        tick(30);
        reg_wr(8'h64, 8'hf0);
        pace(2'h1, 20);
        pace(2'h2, 40);
        pace(2'h3, 80);
        pace(2'h0, 2);
        busy = 1'b1;
        gap(g);
        gap(g);
        chk_gap(300, g);
        busy = 1'b0;
        reg_wr(8'h64, 8'h00);
        gap(g);
        gap(g);
        chk_gap(300, g);
        // Deliberate writes to read-only bits, then restored
        reg_wr(8'h68, 8'hff);
        reg_wr(8'h6a, 8'hff);
        reg_rd(8'h68);
        reg_rd(8'h6a);
        reg_wr(8'h68, 8'h00);
        reg_wr(8'h6a, 8'h00);
        for (int k = 0; k < 16; k++) begin
            r = $random(seed);
            reg_wr(8'h64, {r[3:0], 4'h0});
            reg_wr(8'h65, r[15:8]);
            reg_wr(8'h66, r[23:16]);
            reg_wr(8'h67, {r[5:4], 2'b11, 2'(k), k[2], k[3]});
            reg_wr(8'h68, {2'(k) ^ 2'(k >> 2), r[7:6], 4'h0});
            reg_wr(8'h6a, {r[24], 7'h00});
            for (int a = 8'h64; a <= 8'h6a; a++) reg_rd(8'(a));
            for (int b = 0; b < 12; b++) begin
                r = $random(seed);
                smp.ch = r[1:0];
                smp.kind = r[4:2];
                n = r[9:6] + 8;
                svld = 1'b1;
                repeat (n) begin
                    v = $random(seed);
                    f = v[2:0] != 3'd0;
                    smp.value = (f ^ (smp.kind > 3'd3)) ? 12'(v[17:12])
                                : 12'hfc0 | 12'(v[17:12]);
                    vlow = v[20];
                    tick();
                end
                svld = 1'b0;
                tick(3);
            end
        end
        stop_test();
    end
endmodule
`default_nettype wire
